// ### design/slo_lpf.sv
// First-order low-pass stage, time constant in 0.01 ms units
`include "slo_map.svh"
module slo_lpf #(
  parameter int W = 16,
  parameter int TS_NS = 12500
) (
  // Clock and reset
  input logic core_clk,
  input logic rst,
  // Settings and samples
  input slo_pkg::slo_word_t tc,
  slo_stage_if.stage s
);
  logic [63:0] den;
  logic [63:0] coef;
  logic signed [W:0] diff;
  logic signed [W+18:0] prod;
  logic signed [W+18:0] acc;
  // Divider is combinational; tc moves at most once per control cycle
  assign den = 64'(tc) * 64'(`SLO_TC_UNIT_NS) + 64'(TS_NS);
  assign coef = (64'(TS_NS) << 16) / den;
  assign diff = (W+1)'(s.x) - (W+1)'(s.y);
  assign prod = diff * $signed({1'b0, coef[16:0]});
  assign s.y = acc[W+15:16];
  // Zero time constant gives a unit coefficient, so the stage passes straight
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc <= '0;
      s.ostb <= 1'b0;
    end else begin
      if (s.stb) begin
        acc <= acc + prod;
      end
      s.ostb <= s.stb;
    end
  end
endmodule

// ### design/slo_map.svh
// Offsets, fields, reset values and timing of the servo loop tuning block
// Function
// - Detect digit 0 selects method 1, 1 selects method 2; applied on restart.
// - Feedforward scales position command by gain 0..100 percent, default 0.
// - Feedforward filter time constant 0..6400 in 0.01 ms, default 0.
// - Host proportional-select input forces P control, otherwise PI control.
// - Switch digit picks torque, speed, accel, deviation; 4 disables auto switching.
// - Selected quantity above its level gives P control, otherwise PI.
// - Torque switch level defaults to 200 percent of rated torque.
// - Torque command passes low-pass then notch filters in series, independently.
// - First torque filter time constant 0..65535 in 0.01 ms, default 100.
// - Second torque filter 100..5000 Hz, default 5000; 5000 bypasses it.
// - Second torque filter Q 50..100, default 50, applied immediately.
// - Notch config lowest digit 1 enables first notch, 0 disables.
// - Notch config hundreds digit 1 enables second notch, 0 disables.
// - Each notch has own frequency, Q and depth, applied immediately.
`ifndef SLO_MAP_SVH
`define SLO_MAP_SVH
`define SLO_CLK_NS 50
`define SLO_CTRL_NS 12500
`define SLO_CTRL_CYCLES (`SLO_CTRL_NS / `SLO_CLK_NS)
`define SLO_OFF(i) ((i) * 4)
`define SLO_I_DETECT 0
`define SLO_I_FF_GAIN 1
`define SLO_I_FF_TC 2
`define SLO_I_GSW 3
`define SLO_I_MSEL 4
`define SLO_I_TLVL 5
`define SLO_I_SLVL 6
`define SLO_I_ALVL 7
`define SLO_I_DLVL 8
`define SLO_I_TF1_TC 9
`define SLO_I_TF2_FREQ 10
`define SLO_I_TF2_Q 11
`define SLO_I_NOTCH_CFG 12
`define SLO_I_N1_FREQ 13
`define SLO_I_N1_Q 14
`define SLO_I_N1_DEPTH 15
`define SLO_I_N2_FREQ 16
`define SLO_I_N2_Q 17
`define SLO_I_N2_DEPTH 18
`define SLO_NREGS 19
`define SLO_I_STATUS 19
`define SLO_I_RESTART 20
`define SLO_DET_LSB 8
`define SLO_N2EN_LSB 8
`define SLO_DIGIT_ON 4'h1
`define SLO_MSEL_TORQUE 4'h0
`define SLO_MSEL_SPEED 4'h1
`define SLO_MSEL_ACCEL 4'h2
`define SLO_MSEL_DEV 4'h3
`define SLO_ST_P 0
`define SLO_ST_AUTO 1
`define SLO_ST_HOST 2
`define SLO_ST_DET 3
`define SLO_RST_TLVL 16'h00c8
`define SLO_RST_TF1_TC 16'h0064
`define SLO_FREQ_MAX 16'h1388
`define SLO_FREQ_MIN 16'h0064
`define SLO_TF2_Q_MIN 16'h0032
`define SLO_TF2_Q_MAX 16'h0064
`define SLO_RST_NQ 16'h0046
`define SLO_NQ_MAX 16'h03e8
`define SLO_FF_GAIN_MAX 16'h0064
`define SLO_FF_TC_MAX 16'h1900
`define SLO_DEPTH_FULL 16'h03e8
`define SLO_PCT_FULL 100
`define SLO_Q_UNIT 100
`define SLO_TC_UNIT_NS 10000
`define SLO_TWO_PI_Q16 411775
`define SLO_NS_PER_S 1000000000
`define SLO_RESP_OK 2'h0
`define SLO_RESP_DECERR 2'h3
`endif

// ### design/slo_pkg.sv
// Shared types of the servo loop tuning block
`include "slo_map.svh"
package slo_pkg;
  typedef logic [15:0] slo_word_t;
  typedef slo_word_t slo_regs_t [`SLO_NREGS];
endpackage

// ### design/slo_stage_if.sv
// Sample carrier between the filter stages
interface slo_stage_if #(parameter int W = 16);
  logic stb;
  logic signed [W-1:0] x;
  logic ostb;
  logic signed [W-1:0] y;
  modport src (output stb, output x, input ostb, input y);
  modport stage (input stb, input x, output ostb, output y);
endinterface

// ### design/slo_svf.sv
// State-variable stage: second-order low-pass or notch
`include "slo_map.svh"
module slo_svf #(
  parameter int W = 16,
  parameter int TS_NS = 12500
) (
  // Clock and reset
  input logic core_clk,
  input logic rst,
  // Settings
  input slo_pkg::slo_word_t freq,
  input slo_pkg::slo_word_t q,
  input slo_pkg::slo_word_t depth,
  input logic notch,
  // Samples
  slo_stage_if.stage s
);
  localparam int S = W + 4;
  localparam logic signed [S-1:0] YMAX = S'((64'sd1 <<< (W-1)) - 64'sd1);
  logic [63:0] f_w;
  logic [63:0] d_w;
  logic [63:0] k_w;
  logic signed [S-1:0] lp, bp, next_lp, next_bp, hp, xe, yv;
  function automatic logic signed [S-1:0] mulq(input logic [63:0] c, input logic signed [S-1:0] v);
    logic signed [S+18:0] p;
    p = $signed({1'b0, c[17:0]}) * v;
    return p[S+15:16];
  endfunction
  // Coefficients in Q16; q and depth are held in range by the register file
  assign f_w = 64'(freq) * 64'(TS_NS) * 64'(`SLO_TWO_PI_Q16) / 64'(`SLO_NS_PER_S);
  assign d_w = (64'(`SLO_Q_UNIT) << 16) / ((q == 16'h0000) ? 64'h1 : 64'(q));
  assign k_w = d_w * 64'(`SLO_DEPTH_FULL - depth) / 64'(`SLO_DEPTH_FULL);
  assign xe = S'(s.x);
  always_comb begin
    next_lp = lp + mulq(f_w, bp);
    hp = xe - next_lp - mulq(d_w, bp);
    next_bp = bp + mulq(f_w, hp);
    yv = notch ? xe - mulq(k_w, next_bp) : next_lp;
  end
  // Saturate rather than wrap, a wrapped torque would be a step
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lp <= '0;
      bp <= '0;
      s.y <= '0;
      s.ostb <= 1'b0;
    end else begin
      if (s.stb) begin
        lp <= next_lp;
        bp <= next_bp;
        s.y <= (yv > YMAX) ? W'(YMAX) : (yv < -YMAX - 1) ? W'(-YMAX - 1) : W'(yv);
      end
      s.ostb <= s.stb;
    end
  end
endmodule

// ### design/slo_tuning.sv
// Servo loop tuning: AXI4-Lite settings, mode switch, feedforward and torque filters
`include "slo_map.svh"
module slo_tuning #(
  parameter int W = 16,
  parameter int CTRL_CYCLES = `SLO_CTRL_CYCLES
) (
  // Clock and reset
  input logic core_clk,
  input logic rst,
  // AXI4-Lite write address
  input logic [7:0] s_axi_awaddr,
  input logic [2:0] s_axi_awprot,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // AXI4-Lite read address
  input logic [7:0] s_axi_araddr,
  input logic [2:0] s_axi_arprot,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // Host proportional select, asynchronous pin, high means P control
  input logic proportional_select_in,
  // Loop quantities from the same clock
  input logic signed [W-1:0] pos_cmd_delta,
  input logic signed [W-1:0] torque_cmd,
  input logic signed [W-1:0] speed_cmd,
  input logic signed [W-1:0] accel_in,
  input logic signed [W-1:0] pos_deviation,
  // Loop outputs
  output logic signed [W-1:0] ff_out,
  output logic signed [W-1:0] torque_out,
  output logic torque_valid,
  output logic p_control,
  output logic detect_method_sel
);
  localparam int TS_NS = CTRL_CYCLES * `SLO_CLK_NS;

  slo_pkg::slo_regs_t regs;
  slo_pkg::slo_regs_t act;
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_reg;
  logic restart;
  logic [4:0] aw_idx;
  logic [4:0] ar_idx;
  logic [15:0] cyc_cnt;
  logic ctrl_stb;
  logic psel_meta;
  logic psel_sync;
  logic auto_p;
  logic next_auto;
  logic tf2_on;
  logic n1_on;
  logic n2_on;
  logic signed [W+7:0] ff_prod;
  slo_pkg::slo_word_t status;

  slo_stage_if #(.W(W)) ff_if ();
  slo_stage_if #(.W(W)) tf1_if ();
  slo_stage_if #(.W(W)) tf2_if ();
  slo_stage_if #(.W(W)) n1_if ();
  slo_stage_if #(.W(W)) n2_if ();

  // Reset value of each setting
  function automatic slo_pkg::slo_word_t reset_value(input int i);
    case (i)
      `SLO_I_TLVL: return `SLO_RST_TLVL;
      `SLO_I_TF1_TC: return `SLO_RST_TF1_TC;
      `SLO_I_TF2_FREQ: return `SLO_FREQ_MAX;
      `SLO_I_TF2_Q: return `SLO_TF2_Q_MIN;
      `SLO_I_N1_FREQ: return `SLO_FREQ_MAX;
      `SLO_I_N2_FREQ: return `SLO_FREQ_MAX;
      `SLO_I_N1_Q: return `SLO_RST_NQ;
      `SLO_I_N2_Q: return `SLO_RST_NQ;
      default: return 16'h0000;
    endcase
  endfunction

  // Bound a value to an inclusive range
  function automatic slo_pkg::slo_word_t limit(input slo_pkg::slo_word_t v,
                                               input slo_pkg::slo_word_t lo,
                                               input slo_pkg::slo_word_t hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction

  // Out-of-range writes saturate so the filters never see unstable coefficients
  function automatic slo_pkg::slo_word_t clamp(input logic [4:0] i,
                                               input slo_pkg::slo_word_t v);
    case (i)
      5'(`SLO_I_FF_GAIN): return limit(v, 16'h0000, `SLO_FF_GAIN_MAX);
      5'(`SLO_I_FF_TC): return limit(v, 16'h0000, `SLO_FF_TC_MAX);
      5'(`SLO_I_TF2_FREQ): return limit(v, `SLO_FREQ_MIN, `SLO_FREQ_MAX);
      5'(`SLO_I_TF2_Q): return limit(v, `SLO_TF2_Q_MIN, `SLO_TF2_Q_MAX);
      5'(`SLO_I_N1_FREQ), 5'(`SLO_I_N2_FREQ): return limit(v, `SLO_FREQ_MIN, `SLO_FREQ_MAX);
      5'(`SLO_I_N1_Q), 5'(`SLO_I_N2_Q): return limit(v, `SLO_TF2_Q_MIN, `SLO_NQ_MAX);
      5'(`SLO_I_N1_DEPTH), 5'(`SLO_I_N2_DEPTH): return limit(v, 16'h0000, `SLO_DEPTH_FULL);
      default: return v;
    endcase
  endfunction

  // Magnitude of a signed quantity, one bit wider so the most negative fits
  function automatic logic [W:0] mag(input logic signed [W-1:0] v);
    logic signed [W:0] e;
    e = (W+1)'(v);
    return (e < 0) ? (W+1)'(-e) : (W+1)'(e);
  endfunction

  // Write address and data may arrive in either order
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign wr_fire = aw_hold && w_hold;
  assign aw_idx = aw_addr[6:2];
  assign wr_reg = wr_fire && !aw_addr[7] && (aw_addr[1:0] == 2'h0) &&
                  (aw_idx < 5'(`SLO_NREGS));
  assign restart = wr_fire && !aw_addr[7] && (aw_addr[1:0] == 2'h0) &&
                   (aw_idx == 5'(`SLO_I_RESTART)) && w_strb[0] && w_data[0];

  // Write channel capture and response
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SLO_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_reg || restart ||
                        (aw_idx == 5'(`SLO_I_RESTART) && !aw_addr[7] && aw_addr[1:0] == 2'h0)) ?
                       `SLO_RESP_OK : `SLO_RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Setting registers; only the low two byte lanes carry data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < `SLO_NREGS; i++) begin
        regs[i] <= reset_value(i);
      end
    end else if (wr_reg) begin
      regs[aw_idx] <= clamp(aw_idx, {w_strb[1] ? w_data[15:8] : regs[aw_idx][15:8],
                                     w_strb[0] ? w_data[7:0] : regs[aw_idx][7:0]});
    end
  end

  // Control cycle tick
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cyc_cnt <= 16'h0000;
      ctrl_stb <= 1'b0;
    end else if (cyc_cnt == 16'(CTRL_CYCLES - 1)) begin
      cyc_cnt <= 16'h0000;
      ctrl_stb <= 1'b1;
    end else begin
      cyc_cnt <= cyc_cnt + 16'h0001;
      ctrl_stb <= 1'b0;
    end
  end

  // Loop works on a snapshot so a write never lands mid cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < `SLO_NREGS; i++) begin
        act[i] <= reset_value(i);
      end
    end else if (ctrl_stb) begin
      act <= regs;
    end
  end

  // Detection method follows the setting only at a restart request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      detect_method_sel <= 1'b0;
    end else if (restart) begin
      detect_method_sel <= (regs[`SLO_I_DETECT][`SLO_DET_LSB +: 4] == `SLO_DIGIT_ON);
    end
  end

  // Host select pin synchroniser
  always_ff @(posedge core_clk) begin
    if (rst) begin
      psel_meta <= 1'b0;
      psel_sync <= 1'b0;
    end else begin
      psel_meta <= proportional_select_in;
      psel_sync <= psel_meta;
    end
  end

  // Automatic switch condition from the selected quantity
  always_comb begin
    next_auto = 1'b0;
    case (act[`SLO_I_MSEL][3:0])
      `SLO_MSEL_TORQUE: next_auto = mag(torque_cmd) > (W+1)'(act[`SLO_I_TLVL]);
      `SLO_MSEL_SPEED: next_auto = mag(speed_cmd) > (W+1)'(act[`SLO_I_SLVL]);
      `SLO_MSEL_ACCEL: next_auto = mag(accel_in) > (W+1)'(act[`SLO_I_ALVL]);
      `SLO_MSEL_DEV: next_auto = mag(pos_deviation) > (W+1)'(act[`SLO_I_DLVL]);
      default: next_auto = 1'b0;
    endcase
  end

  // Evaluated once per control cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      auto_p <= 1'b0;
    end else if (ctrl_stb) begin
      auto_p <= next_auto;
    end
  end

  // Either source forces P control; the pin is not gated by the tick
  always_ff @(posedge core_clk) begin
    if (rst) begin
      p_control <= 1'b0;
    end else begin
      p_control <= psel_sync || auto_p;
    end
  end

  // Feedforward scaling; gain is at most 100 so eight extra bits suffice
  assign ff_prod = (W+8)'(pos_cmd_delta) * $signed({1'b0, act[`SLO_I_FF_GAIN][6:0]});

  // Stage inputs latched on the tick
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ff_if.x <= '0;
      ff_if.stb <= 1'b0;
      tf1_if.x <= '0;
      tf1_if.stb <= 1'b0;
    end else begin
      if (ctrl_stb) begin
        ff_if.x <= W'(ff_prod / (W+8)'(`SLO_PCT_FULL));
        tf1_if.x <= torque_cmd;
      end
      ff_if.stb <= ctrl_stb;
      tf1_if.stb <= ctrl_stb;
    end
  end

  // Feedforward smoothing
  slo_lpf #(.W(W), .TS_NS(TS_NS)) u_ff_lpf (
    .core_clk(core_clk),
    .rst(rst),
    .tc(act[`SLO_I_FF_TC]),
    .s(ff_if)
  );

  // First torque filter
  slo_lpf #(.W(W), .TS_NS(TS_NS)) u_tf1 (
    .core_clk(core_clk),
    .rst(rst),
    .tc(act[`SLO_I_TF1_TC]),
    .s(tf1_if)
  );

  // Stage enables; a bypassed stage still runs but its output is skipped
  assign tf2_on = act[`SLO_I_TF2_FREQ] != `SLO_FREQ_MAX;
  assign n1_on = act[`SLO_I_NOTCH_CFG][3:0] == `SLO_DIGIT_ON;
  assign n2_on = act[`SLO_I_NOTCH_CFG][`SLO_N2EN_LSB +: 4] == `SLO_DIGIT_ON;

  // Series chain; the skipped stage costs one cycle of latency only
  assign tf2_if.x = tf1_if.y;
  assign tf2_if.stb = tf1_if.ostb;
  assign n1_if.x = tf2_on ? tf2_if.y : tf2_if.x;
  assign n1_if.stb = tf2_if.ostb;
  assign n2_if.x = n1_on ? n1_if.y : n1_if.x;
  assign n2_if.stb = n1_if.ostb;

  // Second torque filter
  slo_svf #(.W(W), .TS_NS(TS_NS)) u_tf2 (
    .core_clk(core_clk),
    .rst(rst),
    .freq(act[`SLO_I_TF2_FREQ]),
    .q(act[`SLO_I_TF2_Q]),
    .depth(16'h0000),
    .notch(1'b0),
    .s(tf2_if)
  );

  // First notch
  slo_svf #(.W(W), .TS_NS(TS_NS)) u_n1 (
    .core_clk(core_clk),
    .rst(rst),
    .freq(act[`SLO_I_N1_FREQ]),
    .q(act[`SLO_I_N1_Q]),
    .depth(act[`SLO_I_N1_DEPTH]),
    .notch(1'b1),
    .s(n1_if)
  );

  // Second notch
  slo_svf #(.W(W), .TS_NS(TS_NS)) u_n2 (
    .core_clk(core_clk),
    .rst(rst),
    .freq(act[`SLO_I_N2_FREQ]),
    .q(act[`SLO_I_N2_Q]),
    .depth(act[`SLO_I_N2_DEPTH]),
    .notch(1'b1),
    .s(n2_if)
  );

  // Output registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      torque_out <= '0;
      torque_valid <= 1'b0;
      ff_out <= '0;
    end else begin
      if (n2_if.ostb) begin
        torque_out <= n2_on ? n2_if.y : n2_if.x;
      end
      if (ff_if.ostb) begin
        ff_out <= ff_if.y;
      end
      torque_valid <= n2_if.ostb;
    end
  end

  // Live state for software
  always_comb begin
    status = 16'h0000;
    status[`SLO_ST_P] = p_control;
    status[`SLO_ST_AUTO] = auto_p;
    status[`SLO_ST_HOST] = psel_sync;
    status[`SLO_ST_DET] = detect_method_sel;
  end

  // Read channel, one beat in flight
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_idx = s_axi_araddr[6:2];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SLO_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SLO_RESP_DECERR;
      if (!s_axi_araddr[7] && s_axi_araddr[1:0] == 2'h0) begin
        if (ar_idx < 5'(`SLO_NREGS)) begin
          s_axi_rdata <= {16'h0000, regs[ar_idx]};
          s_axi_rresp <= `SLO_RESP_OK;
        end else if (ar_idx == 5'(`SLO_I_STATUS)) begin
          s_axi_rdata <= {16'h0000, status};
          s_axi_rresp <= `SLO_RESP_OK;
        end else if (ar_idx == 5'(`SLO_I_RESTART)) begin
          s_axi_rresp <= `SLO_RESP_OK;
        end
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### testbench/slo_host_model.sv
// Upper controller model driving the host proportional select pin
module slo_host_model (
  // Clock
  input logic core_clk,
  // Request from the bench
  input logic want_p,
  // Pin to the drive
  output logic proportional_select_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin moves just after an edge, high asks for P control; one driver only
  always @(posedge core_clk) begin
    proportional_select_in <= want_p;
  end
endmodule

// ### testbench/slo_tuning_props.sv
// Concurrent checks on the servo loop tuning top ports
module slo_tuning_props (
  // Clock and reset
  input logic core_clk,
  input logic rst,
  // Register bus
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // Loop side
  input logic proportional_select_in,
  input logic torque_valid,
  input logic p_control
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Both write channels taken on one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Select held long enough to cross the two-stage synchroniser
  sequence s_pin_held;
    proportional_select_in [*4];
  endsequence
  property p_pin_p;
    s_pin_held |-> p_control;
  endproperty
  a_pin_p: assert property (p_pin_p) else $error("select not giving P");
  property p_bresp;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write answer late");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rresp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rresp: assert property (p_rresp) else $error("read answer late");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
  property p_arblk;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arblk: assert property (p_arblk) else $error("read taken while busy");
  property p_awblk;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_awblk: assert property (p_awblk) else $error("write taken while busy");
  // One update per control cycle, never a long pulse
  property p_tvpulse;
    torque_valid |=> !torque_valid [*4];
  endproperty
  a_tvpulse: assert property (p_tvpulse) else $error("torque strobe too long");
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the servo loop tuning block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CT = 8;
  logic core_clk, rst, want_p;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, proportional_select_in;
  logic signed [15:0] pos_cmd_delta, torque_cmd, speed_cmd, accel_in, pos_deviation;
  logic signed [15:0] ff_out, torque_out;
  logic torque_valid, p_control, detect_method_sel;
  logic [4:0] pe;
  int n_fail, total_checks;
  slo_tuning #(.CTRL_CYCLES(CT)) u_dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .proportional_select_in, .pos_cmd_delta, .torque_cmd,
    .speed_cmd, .accel_in, .pos_deviation, .ff_out, .torque_out, .torque_valid,
    .p_control, .detect_method_sel);
  slo_host_model u_host (.core_clk, .want_p, .proportional_select_in);
  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus write; each channel released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  // Bus read into rv and rsp
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, rv, e);
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                     input string nm);
    wr(a, d);
    rchk(a, e, nm);
  endtask
  task automatic ticks(input int n);
    repeat (n * CT) @(posedge core_clk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (6000) @(posedge core_clk);
    n_fail++;
    finish_test;
  end
  // Main sequence
  initial begin
    n_fail = 0;
    total_checks = 0;
    {rst, want_p, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h10;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    {s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = {6'h0, 32'h0, 4'hf};
    {pos_cmd_delta, torque_cmd, speed_cmd, accel_in, pos_deviation} = 80'h0;
    pe = 5'h05;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rchk(8'h00, 32'h0, "detect cfg");
    rchk(8'h04, 32'h0, "ff gain");
    rchk(8'h08, 32'h0, "ff tc");
    rchk(8'h10, 32'h0, "mode sel");
    rchk(8'h14, 32'hc8, "torque level");
    rchk(8'h24, 32'h64, "filter1 tc");
    rchk(8'h28, 32'h1388, "filter2 freq");
    rchk(8'h2c, 32'h32, "filter2 q");
    rchk(8'h30, 32'h0, "notch cfg");
    rd(8'h58);
    chk("unmapped resp", {30'h0, rsp}, 32'h3);
    $display("test reset_values done");
    wrc(8'h04, 32'h96, 32'h64, "ff gain max");
    wrc(8'h08, 32'h1b58, 32'h1900, "ff tc max");
    wrc(8'h28, 32'h32, 32'h64, "filter2 freq min");
    wrc(8'h2c, 32'hc8, 32'h64, "filter2 q max");
    wrc(8'h28, 32'h1388, 32'h1388, "filter2 freq top");
    // Motor stopped and notches well above four times the loop gain
    wrc(8'h34, 32'h7d0, 32'h7d0, "notch1 freq");
    wrc(8'h40, 32'h9c4, 32'h9c4, "notch2 freq");
    wrc(8'h3c, 32'h1f4, 32'h1f4, "notch1 depth");
    wrc(8'h44, 32'h50, 32'h50, "notch2 q");
    wrc(8'h30, 32'h101, 32'h101, "notch enables");
    wr(8'h30, 32'h0);
    wr(8'h08, 32'h0);
    $display("test ranges done");
    wr(8'h00, 32'h100);
    ticks(2);
    chk("detect before restart", detect_method_sel, 32'h0);
    wr(8'h50, 32'h1);
    ticks(1);
    chk("detect after restart", detect_method_sel, 32'h1);
    want_p <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("host p", p_control, 32'h1);
    rchk(8'h4c, 32'hd, "status");
    want_p <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("host pi", p_control, 32'h0);
    $display("test detect_host done");
    wr(8'h14, 32'ha);
    wr(8'h18, 32'h14);
    wr(8'h1c, 32'h1e);
    wr(8'h20, 32'h28);
    torque_cmd <= 16'h000f;
    speed_cmd <= 16'h000f;
    accel_in <= 16'h0023;
    pos_deviation <= 16'h0023;
    // Each quantity against its own level; selector 4 turns switching off
    for (int m = 0; m < 5; m++) begin
      wr(8'h10, m);
      ticks(3);
      chk("auto p", p_control, {31'h0, pe[m]});
    end
    $display("test mode_switch done");
    wr(8'h24, 32'h0);
    torque_cmd <= 16'h04d2;
    ticks(3);
    chk("torque chain", {16'h0, torque_out}, 32'h04d2);
    wr(8'h04, 32'h32);
    pos_cmd_delta <= 16'hfff9;
    ticks(3);
    chk("ff half", {16'h0, ff_out}, 32'hfffd);
    wr(8'h04, 32'h50);
    ticks(3);
    chk("ff eighty", {16'h0, ff_out}, 32'hfffb);
    $display("test loop_paths done");
    finish_test;
  end
endmodule
bind slo_tuning slo_tuning_props u_props (.core_clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .proportional_select_in,
  .torque_valid, .p_control);
